// ### rtl/insn_decode_consts.svh
// Purpose: constants for the instruction decoder
// Assumes: 16-bit instruction words
// Notes: opcode prefixes and field positions
`ifndef INSN_DECODE_CONSTS_SVH
`define INSN_DECODE_CONSTS_SVH
`define PFX_MOVE_FF 4'hC
`define PFX_SECOND 4'hF
`define PFX_JUMP 4'hD
`define PFX_BRANCH 4'hE
`define OP6_ADDC 6'h08
`define OP6_ADD 6'h09
`define OP7_MUL 7'h01
`define OP7_CLR 7'h35
`define OP8_CALL_HI 7'h76
`define OP8_GOTO 8'hEF
`define LOW_STANDBY 8'h03
`define LOW_WDT 8'h04
`define LOW_PUSH 8'h05
`define LOW_POP 8'h06
`define LOW_RETFAST 7'h08
`define LOW_RET 7'h09
`define LOW_TBL_RD 6'h02
`define LOW_TBL_WR 6'h03
`define TIMER_ZERO_ADDR 8'hD6
`define INSN_PERIOD_OSC 3'h4
`endif

// ### rtl/insn_decode_pkg.sv
// Purpose: types for the instruction decoder
// Assumes: nothing
// Notes: one-hot sequencer states
package insn_decode_pkg;
    typedef enum logic [2:0] {
        ST_EXEC = 3'h1,
        ST_SECOND = 3'h2,
        ST_FLUSH = 3'h4
    } seq_e;
    typedef struct packed {
        seq_e seq;
        logic [1:0] osc_ph;
        logic [7:0] src_lo;
        logic [7:0] tgt_lo;
        logic call_pend;
        logic fast_pend;
        logic tbl_write_busy;
        logic [11:0] addr;
        logic bank_sel;
        logic to_acc;
        logic [2:0] bit_idx;
        logic [7:0] lit;
        logic [10:0] offset;
        logic [19:0] target;
        logic [3:0] alu_op;
        logic [1:0] tbl_mode;
        logic use_shadow;
        logic pin_src;
        logic clr_prescale;
        logic flag_upd;
        logic wdt_pd_upd;
        logic irq_reen;
        logic stack_push;
        logic stack_pop;
        logic take_jump;
        logic is_nop;
        logic stall;
    } dec_s;
endpackage

// ### rtl/mcu_instruction_decoder.sv
// Purpose: decode 16-bit instruction words into datapath controls
// Assumes: one instruction word per instruction cycle, status flags as inputs
// Notes: outputs registered; they describe the word taken on the previous cycle
// Behaviour
// RULE1: access bit 0 uses access RAM, 1 uses bank select register.
// RULE2: destination bit 0 writes accumulator, 1 writes the file register.
// RULE3: bit instructions pick bit 0 to 7 via three-bit field.
// RULE4: single-word file address is eight bits, 0x00 to 0xFF.
// RULE5: file-to-file move takes two cycles, 12-bit source then destination.
// RULE6: table access uses 21-bit pointer, four modes, eight-bit latch.
// RULE7: fast bit 1 uses shadow registers on call or return, 0 not.
// RULE8: a lone second word with prefix 1111 acts as no-operation.
// RULE9: program counter change or true test costs an extra no-op cycle.
// RULE10: port read-modify-write takes pin levels as source.
// RULE11: flagged write to timer zero count clears its assigned prescaler.
// RULE12: a started table write continues until terminated.
// RULE13: byte ops: opcode 15:10, destination 9, access 8, address 7:0.
// RULE14: literal ops take eight-bit immediate from low byte.
// RULE15: absolute jump and call build 20-bit target from two words.
// RULE16: relative jump is prefix 1101, bit 0, 11-bit offset.
// RULE17: conditional branches prefix 1110 with eight condition codes.
// RULE18: add with carry is 0010 00da and updates five flags.
// RULE19: standby and watchdog restart update time-out and power-down bits.
// RULE20: interrupt return takes two cycles and re-enables interrupts.
// RULE21: multiply writes product high and low, flags unchanged.
// RULE22: push and pop move stack top, no flags touched.
// RULE23: one instruction cycle is four oscillator periods.
// RULE24: undefined encodings execute as no-operation.
`timescale 1ns/1ps
`include "insn_decode_consts.svh"
module mcu_instruction_decoder (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [15:0] insn_word,
    input wire logic insn_valid,
    input wire logic [3:0] flags_nvzc,
    input wire logic port_target,
    input wire logic prescale_on_timer,
    input wire logic tbl_write_done,
    output logic [11:0] file_addr,
    output logic bank_sel,
    output logic to_acc,
    output logic [2:0] bit_idx,
    output logic [7:0] literal,
    output logic [10:0] jump_offset,
    output logic [19:0] jump_target,
    output logic [3:0] alu_op,
    output logic [1:0] tbl_mode,
    output logic tbl_write_busy,
    output logic use_shadow,
    output logic pin_src,
    output logic clr_prescale,
    output logic flag_upd,
    output logic wdt_pd_upd,
    output logic irq_reen,
    output logic stack_push,
    output logic stack_pop,
    output logic take_jump,
    output logic is_nop,
    output logic stall_fetch,
    output logic [1:0] osc_phase
);
    // ========================================
    // helpers
    function automatic logic cond_true(input logic [2:0] cc, input logic [3:0] f);
        logic v;
        v = 1'b0;
        case (cc[2:1])
            2'h0: v = f[1];
            2'h1: v = f[0];
            2'h2: v = f[2];
            default: v = f[3];
        endcase
        cond_true = v ^ cc[0];
    endfunction

    insn_decode_pkg::dec_s s_q, s_d;
    logic [3:0] pfx;
    assign pfx = insn_word[15:12];
    logic word_taken;
    assign word_taken = insn_valid && s_q.seq == insn_decode_pkg::ST_EXEC;

    // ========================================
    // next-state decode
    always_comb begin
        s_d = s_q;
        s_d.osc_ph = s_q.osc_ph + 2'h1; // [RULE23]
        s_d.flag_upd = 1'b0;
        s_d.wdt_pd_upd = 1'b0;
        s_d.irq_reen = 1'b0;
        s_d.stack_push = 1'b0;
        s_d.stack_pop = 1'b0;
        s_d.take_jump = 1'b0;
        s_d.clr_prescale = 1'b0;
        s_d.pin_src = 1'b0;
        s_d.use_shadow = 1'b0;
        s_d.is_nop = 1'b0;
        if (s_q.tbl_write_busy && tbl_write_done) begin
            s_d.tbl_write_busy = 1'b0; // [RULE12]
        end
        case (s_q.seq)
            insn_decode_pkg::ST_FLUSH: begin
                s_d.is_nop = 1'b1; // [RULE9]
                s_d.seq = insn_decode_pkg::ST_EXEC;
            end
            insn_decode_pkg::ST_SECOND: begin
                if (insn_valid) begin
                    s_d.seq = insn_decode_pkg::ST_EXEC;
                    if (s_q.call_pend) begin
                        s_d.target = {insn_word[11:0], s_q.tgt_lo}; // [RULE15]
                        s_d.take_jump = 1'b1;
                        s_d.use_shadow = s_q.fast_pend; // [RULE7]
                    end else begin
                        s_d.addr = insn_word[11:0]; // [RULE5]
                    end
                end
            end
            insn_decode_pkg::ST_EXEC: begin
                if (insn_valid) begin
                    s_d.is_nop = 1'b1; // [RULE24]
                    s_d.addr = {4'h0, insn_word[7:0]}; // [RULE4] [RULE13]
                    s_d.to_acc = ~insn_word[9]; // [RULE2]
                    s_d.bank_sel = insn_word[8]; // [RULE1]
                    s_d.bit_idx = insn_word[11:9]; // [RULE3]
                    s_d.lit = insn_word[7:0]; // [RULE14]
                    s_d.alu_op = insn_word[15:12];
                    if (pfx == `PFX_MOVE_FF) begin
                        s_d.addr = insn_word[11:0]; // [RULE5]
                        s_d.call_pend = 1'b0;
                        s_d.is_nop = 1'b0;
                        s_d.seq = insn_decode_pkg::ST_SECOND;
                    end else if (pfx == `PFX_SECOND) begin
                        s_d.is_nop = 1'b1; // [RULE8]
                    end else if (pfx == `PFX_JUMP) begin
                        s_d.offset = insn_word[10:0]; // [RULE16]
                        s_d.take_jump = 1'b1;
                        s_d.stack_push = insn_word[11];
                        s_d.is_nop = 1'b0;
                        s_d.seq = insn_decode_pkg::ST_FLUSH; // [RULE9]
                    end else if (pfx == `PFX_BRANCH && insn_word[11] == 1'b0) begin
                        s_d.offset = {{3{insn_word[7]}}, insn_word[7:0]};
                        s_d.is_nop = 1'b0;
                        if (cond_true(insn_word[10:8], flags_nvzc)) begin // [RULE17]
                            s_d.take_jump = 1'b1;
                            s_d.seq = insn_decode_pkg::ST_FLUSH; // [RULE9]
                        end
                    end else if (insn_word[15:9] == `OP8_CALL_HI ||
                                 insn_word[15:8] == `OP8_GOTO) begin
                        s_d.tgt_lo = insn_word[7:0]; // [RULE15]
                        s_d.call_pend = 1'b1;
                        s_d.fast_pend = (insn_word[15:8] != `OP8_GOTO) && insn_word[8];
                        s_d.stack_push = insn_word[15:8] != `OP8_GOTO;
                        s_d.is_nop = 1'b0;
                        s_d.seq = insn_decode_pkg::ST_SECOND;
                    end else if (insn_word[15:8] == 8'h00) begin
                        if (insn_word[7:0] == `LOW_STANDBY || insn_word[7:0] == `LOW_WDT) begin
                            s_d.wdt_pd_upd = 1'b1; // [RULE19]
                            s_d.is_nop = 1'b0;
                        end else if (insn_word[7:0] == `LOW_PUSH) begin
                            s_d.stack_push = 1'b1; // [RULE22]
                            s_d.is_nop = 1'b0;
                        end else if (insn_word[7:0] == `LOW_POP) begin
                            s_d.stack_pop = 1'b1; // [RULE22]
                            s_d.is_nop = 1'b0;
                        end else if (insn_word[7:1] == `LOW_RETFAST ||
                                     insn_word[7:1] == `LOW_RET) begin
                            s_d.stack_pop = 1'b1;
                            s_d.take_jump = 1'b1;
                            s_d.use_shadow = insn_word[0]; // [RULE7]
                            s_d.irq_reen = insn_word[7:1] == `LOW_RETFAST; // [RULE20]
                            s_d.is_nop = 1'b0;
                            s_d.seq = insn_decode_pkg::ST_FLUSH;
                        end else if (insn_word[7:2] == `LOW_TBL_RD ||
                                     insn_word[7:2] == `LOW_TBL_WR) begin
                            s_d.tbl_mode = insn_word[1:0]; // [RULE6]
                            s_d.is_nop = 1'b0;
                            s_d.seq = insn_decode_pkg::ST_FLUSH;
                            if (insn_word[7:2] == `LOW_TBL_WR) begin
                                s_d.tbl_write_busy = 1'b1; // [RULE12]
                            end
                        end
                    end else if (insn_word[15:9] == `OP7_MUL) begin
                        s_d.is_nop = 1'b0; // [RULE21]
                    end else if (insn_word[15:10] == `OP6_ADDC ||
                                 insn_word[15:10] == `OP6_ADD) begin
                        s_d.flag_upd = 1'b1; // [RULE18]
                        s_d.is_nop = 1'b0;
                        s_d.pin_src = port_target; // [RULE10]
                        s_d.clr_prescale = insn_word[9] && prescale_on_timer &&
                                           insn_word[7:0] == `TIMER_ZERO_ADDR; // [RULE11]
                    end
                end
            end
            default: s_d.seq = insn_decode_pkg::ST_EXEC;
        endcase
        // stall kept in a flop so the fetch hold leaves straight from a register
        s_d.stall = s_d.seq != insn_decode_pkg::ST_EXEC;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.seq <= insn_decode_pkg::ST_EXEC;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================
    // outputs
    assign file_addr = s_q.addr;
    assign bank_sel = s_q.bank_sel;
    assign to_acc = s_q.to_acc;
    assign bit_idx = s_q.bit_idx;
    assign literal = s_q.lit;
    assign jump_offset = s_q.offset;
    assign jump_target = s_q.target;
    assign alu_op = s_q.alu_op;
    assign tbl_mode = s_q.tbl_mode;
    assign tbl_write_busy = s_q.tbl_write_busy;
    assign use_shadow = s_q.use_shadow;
    assign pin_src = s_q.pin_src;
    assign clr_prescale = s_q.clr_prescale;
    assign flag_upd = s_q.flag_upd;
    assign wdt_pd_upd = s_q.wdt_pd_upd;
    assign irq_reen = s_q.irq_reen;
    assign stack_push = s_q.stack_push;
    assign stack_pop = s_q.stack_pop;
    assign take_jump = s_q.take_jump;
    assign is_nop = s_q.is_nop;
    assign stall_fetch = s_q.stall;
    assign osc_phase = s_q.osc_ph;

    // ========================================
    // checks
    a_flush_nop: assert property (@(posedge core_clk) disable iff (rst) // [RULE9]
        s_q.seq == insn_decode_pkg::ST_FLUSH |=> is_nop) else $error("flush not nop");
    a_jump_two_cyc: assert property (@(posedge core_clk) disable iff (rst) // [RULE16]
        (insn_valid && s_q.seq == insn_decode_pkg::ST_EXEC && pfx == `PFX_JUMP)
        |=> take_jump ##1 is_nop) else $error("jump not two cycles");
    a_second_nop: assert property (@(posedge core_clk) disable iff (rst) // [RULE8]
        (insn_valid && s_q.seq == insn_decode_pkg::ST_EXEC && pfx == `PFX_SECOND)
        |=> is_nop && !take_jump) else $error("lone second word acts");
    a_dest_bit: assert property (@(posedge core_clk) disable iff (rst) // [RULE2]
        (insn_valid && s_q.seq == insn_decode_pkg::ST_EXEC) |=> to_acc == !$past(insn_word[9]))
        else $error("destination wrong");
    a_access_bit: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
        (insn_valid && s_q.seq == insn_decode_pkg::ST_EXEC) |=> bank_sel == $past(insn_word[8]))
        else $error("access bit wrong");
    a_move_src: assert property (@(posedge core_clk) disable iff (rst) // [RULE5]
        (insn_valid && s_q.seq == insn_decode_pkg::ST_EXEC && pfx == `PFX_MOVE_FF)
        |=> stall_fetch && file_addr == $past(insn_word[11:0])) else $error("move src");
    a_wdt_upd: assert property (@(posedge core_clk) disable iff (rst) // [RULE19]
        (insn_valid && s_q.seq == insn_decode_pkg::ST_EXEC && insn_word == 16'h0004)
        |=> wdt_pd_upd) else $error("watchdog bits not updated");
    a_tbl_hold: assert property (@(posedge core_clk) disable iff (rst) // [RULE12]
        (tbl_write_busy && !tbl_write_done) |=> tbl_write_busy) else $error("write cut");
    c_jump: cover property (@(posedge core_clk) take_jump ##1 is_nop);
    c_move: cover property (@(posedge core_clk) stall_fetch && !take_jump);
    c_tbl: cover property (@(posedge core_clk) tbl_write_busy);
    c_call_done: cover property (@(posedge core_clk) take_jump && !stall_fetch);
    c_tbl_done: cover property (@(posedge core_clk) tbl_write_busy ##1 !tbl_write_busy);
    a_bit_field: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
        word_taken
        |=> bit_idx == $past(insn_word[11:9]))
        else $error("bit index wrong");
    a_file_addr: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
        (word_taken && pfx != `PFX_MOVE_FF)
        |=> file_addr == {4'h0, $past(insn_word[7:0])})
        else $error("file address wrong");
    a_byte_fields: assert property (@(posedge core_clk) disable iff (rst) // [RULE13]
        (word_taken && pfx == 4'h2)
        |=> alu_op == 4'h2 && bank_sel == $past(insn_word[8]) && to_acc == !$past(insn_word[9]))
        else $error("byte fields wrong");
    a_literal: assert property (@(posedge core_clk) disable iff (rst) // [RULE14]
        word_taken
        |=> literal == $past(insn_word[7:0]))
        else $error("literal wrong");
    a_move_dst: assert property (@(posedge core_clk) disable iff (rst) // [RULE5]
        (insn_valid && s_q.seq == insn_decode_pkg::ST_SECOND && !s_q.call_pend)
        |=> file_addr == $past(insn_word[11:0]) && !stall_fetch)
        else $error("move destination wrong");
    a_call_target: assert property (@(posedge core_clk) disable iff (rst) // [RULE15]
        (insn_valid && s_q.seq == insn_decode_pkg::ST_SECOND && s_q.call_pend)
        |=> take_jump && jump_target == {$past(insn_word[11:0]), $past(s_q.tgt_lo)})
        else $error("absolute target wrong");
    a_rel_offset: assert property (@(posedge core_clk) disable iff (rst) // [RULE16]
        (word_taken && pfx == `PFX_JUMP)
        |=> jump_offset == $past(insn_word[10:0]))
        else $error("relative offset wrong");
    a_branch_len: assert property (@(posedge core_clk) disable iff (rst) // [RULE9]
        (word_taken && pfx == `PFX_BRANCH && !insn_word[11])
        |=> take_jump == stall_fetch)
        else $error("branch length wrong");
    a_branch_zero: assert property (@(posedge core_clk) disable iff (rst) // [RULE17]
        (word_taken && insn_word[15:8] == 8'hE0)
        |=> take_jump == $past(flags_nvzc[1]))
        else $error("zero branch wrong");
    a_branch_ncarry: assert property (@(posedge core_clk) disable iff (rst) // [RULE17]
        (word_taken && insn_word[15:8] == 8'hE3)
        |=> take_jump == !$past(flags_nvzc[0]))
        else $error("no carry branch wrong");
    a_fast_ret: assert property (@(posedge core_clk) disable iff (rst) // [RULE7]
        (word_taken && insn_word[15:2] == 14'h0004)
        |=> use_shadow == $past(insn_word[0]))
        else $error("fast return wrong");
    a_irq_reen: assert property (@(posedge core_clk) disable iff (rst) // [RULE20]
        (word_taken && insn_word[15:1] == 15'h0008)
        |=> irq_reen && take_jump ##1 is_nop)
        else $error("interrupt return wrong");
    a_mul_flags: assert property (@(posedge core_clk) disable iff (rst) // [RULE21]
        (word_taken && insn_word[15:9] == `OP7_MUL)
        |=> !flag_upd && !is_nop)
        else $error("multiply touched flags");
    a_stack_flags: assert property (@(posedge core_clk) disable iff (rst) // [RULE22]
        (word_taken && (insn_word == 16'h0005 || insn_word == 16'h0006))
        |=> stack_push != stack_pop && !flag_upd && !stall_fetch)
        else $error("push or pop wrong");
    a_addc_flags: assert property (@(posedge core_clk) disable iff (rst) // [RULE18]
        (word_taken && insn_word[15:10] == `OP6_ADDC)
        |=> flag_upd && !is_nop)
        else $error("add with carry flags");
    a_osc_cycle: assert property (@(posedge core_clk) disable iff (rst) // [RULE23]
        $past(!rst)
        |-> osc_phase == 2'($past(osc_phase) + 2'h1))
        else $error("oscillator phase skipped");
    a_undef_nop: assert property (@(posedge core_clk) disable iff (rst) // [RULE24]
        (word_taken && insn_word == 16'h0001)
        |=> is_nop && !take_jump && !stall_fetch)
        else $error("undefined word acts");
    a_tbl_mode: assert property (@(posedge core_clk) disable iff (rst) // [RULE6]
        (word_taken && insn_word[15:3] == 13'h0001)
        |=> tbl_mode == $past(insn_word[1:0]) && stall_fetch ##1 is_nop)
        else $error("table mode wrong");
    a_prescale_clr: assert property (@(posedge core_clk) disable iff (rst) // [RULE11]
        (word_taken && insn_word[15:11] == 5'h04 && insn_word[9] && prescale_on_timer
        && insn_word[7:0] == `TIMER_ZERO_ADDR) |=> clr_prescale)
        else $error("prescaler not cleared");
    a_pin_src: assert property (@(posedge core_clk) disable iff (rst) // [RULE10]
        (word_taken && insn_word[15:11] == 5'h04)
        |=> pin_src == $past(port_target))
        else $error("pin source wrong");
    a_second_wait: assert property (@(posedge core_clk) disable iff (rst) // [RULE5]
        (s_q.seq == insn_decode_pkg::ST_SECOND && !insn_valid)
        |=> stall_fetch)
        else $error("second word not awaited");
    a_sleep_upd: assert property (@(posedge core_clk) disable iff (rst) // [RULE19]
        (word_taken && insn_word == {8'h00, `LOW_STANDBY})
        |=> wdt_pd_upd && !stall_fetch)
        else $error("standby bits not updated");
endmodule

// ### verif/datapath_model.sv
// Purpose: far-side model that finishes table writes started by the decoder
// Assumes: tbl_write_done is a one-cycle pulse
// Notes: alternates a short and a long write time
`timescale 1ns/1ps
module datapath_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tbl_write_busy,
    output logic tbl_write_done
);
    logic [3:0] cnt_q;
    logic slow_q;
    // a started table write runs until this side ends it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            slow_q <= 1'b0;
            tbl_write_done <= 1'b0;
        end else begin
            tbl_write_done <= 1'b0;
            if (tbl_write_busy && !tbl_write_done) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == (slow_q ? 4'h6 : 4'h1)) begin
                    tbl_write_done <= 1'b1;
                    cnt_q <= 4'h0;
                    slow_q <= ~slow_q;
                end
            end
        end
    end
endmodule

// ### verif/tb_top.sv
// Purpose: self-checking bench for the instruction decoder
// Assumes: a word is taken at the edge after it is offered while fetch runs
// Notes: the driver notes expected results, the monitor compares them
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    typedef struct packed {logic [4:0] k; logic [19:0] v;} note_s;
    localparam int ALU = 0, STL = 2, TBW = 3, ACC = 4, BNK = 5, SHD = 6, NOP = 7, JMP = 8, POP = 9;
    localparam int PSH = 10, IRQ = 11, WDT = 12, FUPD = 13, CLRP = 14, PIN = 15;
    localparam int ADR = 16, BIT = 17, LIT = 18, OFS = 19, TGT = 20, MOD = 21;
    logic core_clk, rst, insn_valid, port_target, prescale_on_timer, tbl_write_done, tk;
    logic [15:0] insn_word, w, flg;
    logic [3:0] flags_nvzc, alu_op;
    logic [11:0] file_addr;
    logic [2:0] bit_idx;
    logic [7:0] literal;
    logic [10:0] jump_offset;
    logic [19:0] jump_target, got;
    logic [1:0] tbl_mode, osc_phase;
    logic bank_sel, to_acc, tbl_write_busy, use_shadow, pin_src, clr_prescale, flag_upd;
    logic wdt_pd_upd, irq_reen, stack_push, stack_pop, take_jump, is_nop, stall_fetch;
    logic [31:0] r;
    int errors = 0, checks = 0, seed = 32'h3E9F, i, j;
    note_s notes[$];
    note_s n;
    logic [7:0] tops [3] = '{8'hEC, 8'hED, 8'hEF};
    logic [15:0] ctl [7] = '{16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0010, 16'h0011, 16'h0001};
    int ck [7] = '{WDT, WDT, PSH, POP, IRQ, IRQ, NOP};
    assign flg = {pin_src, clr_prescale, flag_upd, wdt_pd_upd, irq_reen, stack_push, stack_pop,
        take_jump, is_nop, use_shadow, bank_sel, to_acc, tbl_write_busy, stall_fetch, 2'h0};
    mcu_instruction_decoder i_mcu_instruction_decoder (.core_clk, .rst, .insn_word, .insn_valid,
        .flags_nvzc, .port_target, .prescale_on_timer, .tbl_write_done, .file_addr, .bank_sel,
        .to_acc, .bit_idx, .literal, .jump_offset, .jump_target, .alu_op, .tbl_mode,
        .tbl_write_busy, .use_shadow, .pin_src, .clr_prescale, .flag_upd, .wdt_pd_upd,
        .irq_reen, .stack_push, .stack_pop, .take_jump, .is_nop, .stall_fetch, .osc_phase);
    datapath_model i_datapath_model (.core_clk, .rst, .tbl_write_busy, .tbl_write_done);
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // ==========
    // driver and monitor
    task automatic note(input int k, input logic [19:0] v);
        notes.push_back({k[4:0], v});
    endtask
    task automatic flag(input int k, input logic b);
        notes.push_back({k[4:0], 19'h00000, b});
    endtask
    task automatic put(input logic [15:0] wd, input logic [3:0] f, input bit wt);
        int c;
        c = 0;
        if (wt) begin
            @(posedge core_clk);
            while (stall_fetch !== 1'b0 && c < 50) begin
                @(posedge core_clk);
                c++;
            end
        end
        insn_word <= wd;
        insn_valid <= 1'b1;
        flags_nvzc <= f;
        @(posedge core_clk);
        insn_valid <= 1'b0;
        insn_word <= ~wd;
        #1;
    endtask
    task automatic flush;
        @(posedge core_clk);
        #1;
        flag(NOP, 1'b1);
    endtask
    task automatic endt(input string s);
        @(negedge core_clk);
        $display("test %s done", s);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(negedge core_clk) begin
        while (notes.size() > 0) begin
            n = notes.pop_front();
            case (n.k)
                ADR: got = {12'h000, file_addr[7:0]};
                BIT: got = {17'h00000, bit_idx};
                LIT: got = {12'h000, literal};
                OFS: got = {9'h000, jump_offset};
                TGT: got = jump_target;
                MOD: got = {18'h00000, tbl_mode};
                ALU: got = {16'h0000, alu_op};
                default: got = {19'h00000, flg[n.k[3:0]]};
            endcase
            `CHK(got, n.v)
        end
    end
    initial begin
        #200000;
        errors++;
        test_done();
    end
    // ==========
    // scenarios
    initial begin
        rst = 1'b1;
        insn_word = 16'h0000;
        insn_valid = 1'b0;
        flags_nvzc = 4'h0;
        port_target = 1'b0;
        prescale_on_timer = 1'b0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        for (i = 0; i < 16; i++) begin
            r = $random(seed);
            port_target <= r[16];
            prescale_on_timer <= r[17];
            w = {5'h04, i[0], r[9:0]};
            if (i > 11) w[8:0] = 9'h0D6;
            put(w, r[23:20], 1'b1);
            note(ADR, {12'h000, w[7:0]});
            flag(BNK, w[8]);
            flag(ACC, ~w[9]);
            flag(FUPD, 1'b1);
            flag(PIN, r[16]);
            flag(CLRP, r[17] & w[9] & (w[7:0] == 8'hD6));
            note(ALU, 20'h00002);
        end
        endt("byte");
        for (i = 0; i < 6; i++) begin
            r = $random(seed);
            put({4'h8, r[11:0]}, 4'h0, 1'b1);
            note(BIT, {17'h00000, r[11:9]});
            put({8'h0E, r[19:12]}, 4'h0, 1'b1);
            note(LIT, {12'h000, r[19:12]});
            put({5'h1A, r[30:20]}, 4'h0, 1'b1);
            flag(JMP, 1'b1);
            note(OFS, {9'h000, r[30:20]});
            flush();
        end
        endt("bit literal jump");
        for (i = 0; i < 16; i++) begin
            r = $random(seed);
            case (i[2:1])
                2'h0: tk = r[1];
                2'h1: tk = r[0];
                2'h2: tk = r[2];
                default: tk = r[3];
            endcase
            tk = tk ^ i[0];
            put({5'h1C, i[2:0], r[11:4]}, r[3:0], 1'b1);
            flag(JMP, tk);
            note(OFS, {9'h000, {3{r[11]}}, r[11:4]});
            if (tk) flush();
        end
        endt("branch");
        for (i = 0; i < 3; i++) begin
            r = $random(seed);
            put({tops[i], r[7:0]}, 4'h0, 1'b1);
            flag(STL, 1'b1);
            put({4'hF, r[19:8]}, 4'h0, 1'b0);
            note(TGT, r[19:0]);
            flag(SHD, i == 1);
            flag(STL, 1'b0);
            put({4'hC, r[31:20]}, 4'h0, 1'b1);
            flag(STL, 1'b1);
            put({4'hF, r[11:0]}, 4'h0, 1'b0);
            flag(STL, 1'b0);
            put({4'hF, r[23:12]}, 4'h0, 1'b1);
            flag(NOP, 1'b1);
            flag(JMP, 1'b0);
        end
        endt("two word");
        for (i = 0; i < 7; i++) begin
            put(ctl[i], 4'h0, 1'b1);
            flag(ck[i], 1'b1);
            if (ck[i] == IRQ) flush();
        end
        put(16'h0245, 4'h0, 1'b1);
        flag(NOP, 1'b0);
        endt("control");
        for (i = 0; i < 8; i++) begin
            put({12'h000, 1'b1, i[2:0]}, 4'h0, 1'b1);
            note(MOD, {18'h00000, i[1:0]});
            flag(TBW, i[2]);
            flush();
            j = 0;
            while (tbl_write_busy !== 1'b0 && j < 40) begin
                @(posedge core_clk);
                j++;
            end
            #1;
            flag(TBW, 1'b0);
        end
        endt("table");
        repeat (4) @(posedge core_clk);
        test_done();
    end
endmodule
